// ### sac_pkg.sv
package sac_pkg;

   // Data path widths
   localparam int DATA_W  = 8;
   localparam int CHAN_W  = 4;
   localparam int AXI_AW  = 6;
   localparam int AXI_DW  = 32;

   // Register indices; the byte address is four times the index
   localparam logic [3:0] IDX_PORT   = 4'h3;
   localparam logic [3:0] IDX_RESULT = 4'h8;
   localparam logic [3:0] IDX_STATUS = 4'h9;
   localparam logic [AXI_AW-1:0] ADDR_PORT   = {IDX_PORT, 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_RESULT = {IDX_RESULT, 2'b00};
   localparam logic [AXI_AW-1:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

   // Reset values
   localparam logic [DATA_W-1:0] STATUS_RESET = 8'h00;
   localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;

   // Multiplexer codes seen by the analog front end
   localparam logic [CHAN_W-1:0] CH_LAST_PIN = 4'h7;
   localparam logic [CHAN_W-1:0] CH_HIGH_REF = 4'h8;
   localparam logic [CHAN_W-1:0] CH_MID_REF  = 4'h9;
   localparam logic [CHAN_W-1:0] CH_LOW_REF  = 4'ha;

   // Conversion timing, in converter clock ticks
   localparam int SAMPLE_CYCLES = 12;
   localparam int SETTLE_TICKS  = 4;
   localparam int SAR_STEPS     = 8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Status/control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic              done;
      logic              rc_sel;
      logic              pwr_on;
      logic              rsvd;
      logic [CHAN_W-1:0] chan;
   } sac_status_s;

   // Signals handed to the analog front end
   typedef struct packed {
      logic              conv_en;
      logic              rc_osc_on;
      logic              hold;
      logic [CHAN_W-1:0] mux;
      logic [DATA_W-1:0] dac;
   } sac_afe_s;

   // Gray along idle, sample, compare, finish
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_COMPARE = 2'b11,
      ST_FINISH  = 2'b10
   } sac_state_e;

endpackage

// ### sac_sar_core.sv
`timescale 1ns/1ps
`default_nettype none
module sac_sar_core
   import sac_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Control
   input  wire logic              enable,
   input  wire logic              restart,
   input  wire logic              tick,
   input  wire logic              cmp_high,
   // Results
   output logic                   hold,
   output logic [DATA_W-1:0]      dac,
   output logic [DATA_W-1:0]      sar_value,
   output logic                   done
);

   sac_state_e       state;
   logic [3:0]       tick_cnt;
   logic [2:0]       bit_idx;
   logic [DATA_W-1:0] sar;

   localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_CYCLES - 1);
   localparam logic [3:0] SETTLE_LAST = 4'(SETTLE_TICKS - 1);
   localparam logic [2:0] MSB_IDX     = 3'(SAR_STEPS - 1);

   ////////////////////////////////////////////////////////////////////////
   // Sequencer: sample once, then one bit per step from the MSB
   always_ff @(posedge aclk) begin
      if (!aresetn || !enable) begin
         state    <= ST_IDLE;
         tick_cnt <= 4'h0;
         bit_idx  <= MSB_IDX;
         sar      <= 8'h00;
         done     <= 1'b0;
      end else if (restart) begin
         state    <= ST_SAMPLE;
         tick_cnt <= 4'h0;
         bit_idx  <= MSB_IDX;
         sar      <= 8'h00;
         done     <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               state    <= ST_SAMPLE;
               tick_cnt <= 4'h0;
            end
            ST_SAMPLE: if (tick) begin
               if (tick_cnt == SAMPLE_LAST) begin
                  state    <= ST_COMPARE;
                  tick_cnt <= 4'h0;
                  bit_idx  <= MSB_IDX;
                  sar      <= 8'h80;
               end else begin
                  tick_cnt <= tick_cnt + 4'h1;
               end
            end
            ST_COMPARE: if (tick) begin
               if (tick_cnt == SETTLE_LAST) begin
                  tick_cnt <= 4'h0;
                  // Keep the trial bit only if input is at or above it
                  sar[bit_idx] <= cmp_high;
                  if (bit_idx == 3'h0) begin
                     state <= ST_FINISH;
                  end else begin
                     sar[bit_idx - 3'h1] <= 1'b1;
                     bit_idx <= bit_idx - 3'h1;
                  end
               end else begin
                  tick_cnt <= tick_cnt + 4'h1;
               end
            end
            ST_FINISH: begin
               done     <= 1'b1;
               state    <= ST_SAMPLE;
               tick_cnt <= 4'h0;
            end
         endcase
      end
   end

   // Hold the sample switch closed only while sampling
   always_comb begin
      hold      = (state != ST_SAMPLE);
      dac       = sar;
      sar_value = sar;
   end

endmodule
`default_nettype wire

// ### sac_adc_ctrl.sv
// What this block does
// - Single 8-bit SAR converter behind an eleven-way input multiplexer.
// - Input at high reference gives 0xff, at low gives 0x00, no overflow.
// - Converter steps on the bus clock or on the RC oscillator.
// - Setting rc_clock_select turns the RC oscillator on.
// - Clearing converter_power_on switches the converter off.
// - Eleven selections: eight analog inputs and three reference points.
// - Input is sampled once per conversion and held for all compares.
// - On completion result_reg takes the SAR and the done flag sets.
// - A status write with byte lane 0 strobed aborts, clears the flag and restarts.
// - Reset clears rc_clock_select and converter_power_on.
// - Disabled converter: port pins read as digital inputs.
// - Enabled converter: port pins still read as digital levels.
// - After each conversion another starts on the same channel.
// - Reading result_reg or writing status clears the done flag.
// - Reset leaves status and result registers at zero.
// - Result register at index 0x08, status/control at 0x09.
// - Codes 0-7 pins, 8 high ref, 9 midpoint, 10-15 low ref.
// - Powered converter uses RC clock if selected, else bus clock.
// - Stop state halts converter clocks and the RC oscillator.
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl
   import sac_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // AXI4-Lite write address
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [AXI_DW-1:0] s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [AXI_DW-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Processor state
   input  wire logic              stop_mode,
   // Pins and analog front end
   input  wire logic [DATA_W-1:0] analog_port_pins,
   input  wire logic              rc_osc_clk,
   input  wire logic              comparator_high,
   output sac_afe_s               afe
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   sac_status_s       status;
   logic [DATA_W-1:0] result;
   logic [DATA_W-1:0] pins_s1;
   logic [DATA_W-1:0] pins_s2;
   logic [2:0]        rc_sync;
   logic [1:0]        cmp_sync;
   logic              aw_held;
   logic              w_held;
   logic [AXI_AW-1:0] aw_addr;
   logic [DATA_W-1:0] w_data;
   logic              w_lane0;
   logic              do_write;
   logic              do_read;
   logic              status_write;
   logic              result_read;
   logic              conv_run;
   logic              step_tick;
   logic              core_hold;
   logic [DATA_W-1:0] core_dac;
   logic [DATA_W-1:0] core_sar;
   logic              core_done;
   logic [CHAN_W-1:0] next_mux;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: pins and the RC oscillator are asynchronous
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins_s1 <= 8'h00;
         pins_s2 <= 8'h00;
      end else begin
         pins_s1 <= analog_port_pins;
         pins_s2 <= pins_s1;
      end
   end

   // Third stage feeds the edge detector, never the first one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rc_sync  <= 3'b000;
         cmp_sync <= 2'b00;
      end else begin
         rc_sync  <= {rc_sync[1:0], rc_osc_clk};
         cmp_sync <= {cmp_sync[0], comparator_high};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Converter clock choice and run condition
   always_comb begin
      // Stop state overrides power-on; the flag and result survive it
      conv_run  = status.pwr_on && !stop_mode;
      // RC mode steps on each rising oscillator edge, else every cycle
      step_tick = status.rc_sel ? (rc_sync[1] && !rc_sync[2])
                                : 1'b1;
   end

   // One SAR engine serves every channel
   sac_sar_core u_core (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .enable    (conv_run),
      .restart   (status_write),
      .tick      (step_tick),
      .cmp_high  (cmp_sync[1]),
      .hold      (core_hold),
      .dac       (core_dac),
      .sar_value (core_sar),
      .done      (core_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Channel code to multiplexer code
   always_comb begin
      if (status.chan <= CH_LAST_PIN) begin
         next_mux = status.chan;
      end else if (status.chan == CH_HIGH_REF) begin
         next_mux = CH_HIGH_REF;
      end else if (status.chan == CH_MID_REF) begin
         next_mux = CH_MID_REF;
      end else begin
         next_mux = CH_LOW_REF;
      end
   end

   // Front end outputs are registered; the settle count covers the lag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         afe <= '0;
      end else begin
         afe.conv_en   <= conv_run;
         afe.rc_osc_on <= status.rc_sel && !stop_mode;
         afe.hold      <= core_hold;
         afe.mux       <= next_mux;
         afe.dac       <= core_dac;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data captured in either order
   always_comb begin
      do_write     = aw_held && w_held && !s_axi_bvalid;
      status_write = do_write && (aw_addr == ADDR_STATUS) && w_lane0;
      do_read      = s_axi_arvalid && s_axi_arready;
      result_read  = do_read && (s_axi_araddr == ADDR_RESULT);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= '0;
         s_axi_awready <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held       <= 1'b0;
         w_data       <= 8'h00;
         w_lane0      <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_wready <= !w_held && !s_axi_wready;
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata[DATA_W-1:0];
            w_lane0 <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         // Read-only registers ignore writes but still answer OKAY
         if (aw_addr == ADDR_STATUS || aw_addr == ADDR_RESULT ||
             aw_addr == ADDR_PORT) begin
            s_axi_bresp <= RESP_OKAY;
         end else begin
            s_axi_bresp <= RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status/control register: control fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status.rc_sel <= 1'b0;
         status.pwr_on <= 1'b0;
         status.rsvd   <= 1'b0;
         status.chan   <= 4'h0;
      end else if (status_write) begin
         status.rc_sel <= w_data[6];
         status.pwr_on <= w_data[5];
         status.chan   <= w_data[CHAN_W-1:0];
      end
   end

   // Done flag: a completion in the clearing cycle still sets it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status.done <= 1'b0;
      end else if (core_done) begin
         status.done <= 1'b1;
      end else if (status_write || result_read) begin
         status.done <= 1'b0;
      end
   end

   // Result register loads from the SAR at completion only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= RESULT_RESET;
      end else if (core_done) begin
         result <= core_sar;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel: one outstanding read, answered the next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (do_read) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         unique case (s_axi_araddr)
            // Pin levels are visible whether or not converting
            ADDR_PORT:   s_axi_rdata <= {24'h000000, pins_s2};
            ADDR_RESULT: s_axi_rdata <= {24'h000000, result};
            ADDR_STATUS: s_axi_rdata <= {24'h000000, status};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Port reads during a conversion are legal, only noisier

endmodule
`default_nettype wire

// ### sac_adc_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sac_adc_ctrl_chk
   import sac_pkg::*;
(
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Bus answers
   input wire logic              s_axi_bvalid,
   input wire logic              s_axi_bready,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [AXI_DW-1:0] s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid,
   input wire logic              s_axi_rready,
   // Processor state and front end
   input wire logic              stop_mode,
   input wire sac_afe_s          afe
);
   // Single domain, so clock and reset are stated once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////
   // Converter control
   a_rst_idle: assert property (
      $rose(aresetn) |-> afe == '0 && !s_axi_rvalid)
      else $error("front end not idle after reset");
   a_stop_halt: assert property (
      stop_mode [*2] |-> !afe.conv_en && !afe.rc_osc_on)
      else $error("converter or RC oscillator running in stop");
   // First trial of every conversion is the top bit alone; the idle core
   // also opens the switch after reset, so only a powered converter counts
   a_dac_msb: assert property (
      $rose(afe.hold) && afe.conv_en |-> ##[0:4] afe.dac == 8'h80)
      else $error("first trial code is not the top bit");

   ////////////////////////////////////////
   // Register bus answers
   a_rd_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_rd_stable: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped or changed");
   a_b_stable: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_rd_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_err_zero: assert property (
      s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0)
      else $error("error read carries data");

   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_hold: cover property ($rose(afe.hold));
   c_rc_run: cover property (afe.rc_osc_on && afe.conv_en);
endmodule

bind sac_adc_ctrl sac_adc_ctrl_chk chk (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode, .afe);
`default_nettype wire

// ### sac_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model
   import sac_pkg::*;
(
   // Front-end control from the converter
   input  wire sac_afe_s        afe,
   // Source levels; 9'h100 equals the high reference
   input  wire logic [7:0][8:0] lvl,
   // Pins, RC oscillator and comparator
   output logic [DATA_W-1:0]    pins,
   output logic                 rc_clk,
   output logic                 cmp_high
);
   logic [8:0] vin;
   logic [8:0] held;

   // Selected source; every code past the midpoint reads the low reference
   assign vin = (afe.mux <= CH_LAST_PIN) ? lvl[afe.mux[2:0]] :
                (afe.mux == CH_HIGH_REF) ? 9'h100 :
                (afe.mux == CH_MID_REF)  ? 9'h080 : 9'h000;

   // Capacitor follows the source only while the switch is closed
   always_latch begin
      if (!afe.hold)
         held <= vin;
   end

   // Unpowered comparator gives a dead output, not a guess
   assign cmp_high = afe.conv_en && (held >= {1'b0, afe.dac});

   // Digital view of the pins, threshold at mid supply
   for (genvar i = 0; i < 8; i++) begin : g_pin
      assign pins[i] = lvl[i][8] | lvl[i][7];
   end

   // RC oscillator, unrelated to the bus clock; still while off
   initial rc_clk = 1'b0;
   always #17 rc_clk = afe.rc_osc_on ? ~rc_clk : 1'b0;
endmodule
`default_nettype wire

// ### test_sar_adc_control_8bit.sv
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_control_8bit
   import sac_pkg::*;
;
   // Driven by the bench
   logic              aclk = 1'b0, aresetn = 1'b0, stop_mode = 1'b0;
   logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [AXI_DW-1:0] s_axi_wdata = '0;
   logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic              s_axi_rready = 1'b0;
   // Answers, pins and front end
   logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic              s_axi_arready, s_axi_rvalid, rc_clk, cmp_high;
   logic [1:0]        s_axi_bresp, s_axi_rresp, rr, br;
   logic [AXI_DW-1:0] s_axi_rdata, rd;
   logic [DATA_W-1:0] pins;
   sac_afe_s          afe;
   int                n_mismatch = 0, num_checks = 0, cyc = 0;
   // Source levels; 9'h12c overdrives the high reference
   logic [7:0][8:0]   lvl = {9'h0fe, 9'h080, 9'h001, 9'h12c,
                             9'h0ff, 9'h0aa, 9'h055, 9'h000};

   // Bus clock, 100 MHz
   always #5 aclk = ~aclk;

   sac_adc_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .stop_mode, .analog_port_pins(pins),
      .rc_osc_clk(rc_clk), .comparator_high(cmp_high), .afe);
   sac_afe_model src (.afe, .lvl, .pins, .rc_clk, .cmp_high);

   ////////////////////////////////////////
   // Word compare; case inequality so unknowns never match
   task automatic chk(input logic [31:0] got, exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Bus write: both channels offered together, each dropped once taken
   task automatic axw(input logic [AXI_AW-1:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   // Bus read; data and response land in rd and rr
   task automatic axr(input logic [AXI_AW-1:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [AXI_AW-1:0] a,
                         input logic [31:0] exp, input string m);
      axr(a);
      chk(rd, exp, m);
   endtask

   // Polls status; a slow RC conversion needs about fifty polls
   task automatic wait_done;
      rd = '0;
      for (int i = 0; i < 200 && !rd[7]; i++) axr(ADDR_STATUS);
      chk({31'h0, rd[7]}, 32'h1, "done flag");
   endtask

   // Ideal code: largest trial not above the held level, clipped
   function automatic logic [31:0] code(input int ch);
      if (ch < 8)
         return (lvl[ch] > 9'h0ff) ? 32'hff : {24'h0, lvl[ch][7:0]};
      return (ch == 8) ? 32'hff : (ch == 9) ? 32'h80 : 32'h00;
   endfunction

   ////////////////////////////////////////
   task automatic t_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      ticks(5);
      aresetn <= 1'b1;
      ticks(1);
      chk({31'h0, afe.conv_en | afe.rc_osc_on}, 32'h0,
          "afe");
      rd_chk(ADDR_STATUS, 32'h0, "status");
      axw(ADDR_RESULT, 8'h5a);
      chk({30'h0, br}, {30'h0, RESP_OKAY}, "ro write");
      rd_chk(ADDR_RESULT, 32'h0, "result");
      axr(6'h10);
      chk({30'h0, rr}, {30'h0, RESP_SLVERR}, "unmapped");
      axw(6'h10, 8'h00);
      chk({30'h0, br}, {30'h0, RESP_SLVERR}, "unmapped wr");
      $display("reset test done");
   endtask

   task automatic t_port;
      rd_chk(ADDR_PORT, 32'hdc, "pins off");
      lvl[1] <= 9'h0c8;
      axw(ADDR_STATUS, 8'h21);
      rd_chk(ADDR_PORT, 32'hde, "pins on");
      lvl[1] <= 9'h055;
      $display("port test done");
   endtask

   // Every multiplexer code, bus clock
   task automatic t_conv;
      for (int ch = 0; ch < 16; ch++) begin
         axw(ADDR_STATUS, 8'h20 | 8'(ch));
         wait_done();
         rd_chk(ADDR_STATUS, 32'ha0 | ch, "done set");
         rd_chk(ADDR_RESULT, code(ch), "code");
         rd_chk(ADDR_STATUS, 32'h20 | ch, "read clears");
      end
      $display("conversion test done");
   endtask

   task automatic t_abort;
      axw(ADDR_STATUS, 8'h21);
      wait_done();
      axw(ADDR_STATUS, 8'h23);
      rd_chk(ADDR_STATUS, 32'h23, "write clears");
      wait_done();
      rd_chk(ADDR_RESULT, 32'hff, "new channel");
      axw(ADDR_STATUS, 8'h25);
      ticks(20);
      axw(ADDR_STATUS, 8'h26);
      ticks(30);
      lvl[6] <= 9'h040;
      wait_done();
      rd_chk(ADDR_RESULT, 32'h80, "held sample");
      wait_done();
      rd_chk(ADDR_RESULT, 32'h40, "next run");
      $display("abort test done");
   endtask

   task automatic t_rc;
      axw(ADDR_STATUS, 8'h40);
      ticks(2);
      chk({31'h0, afe.rc_osc_on}, 32'h1, "rc on");
      chk({31'h0, afe.conv_en}, 32'h0, "adc off");
      axw(ADDR_STATUS, 8'h62);
      ticks(60);
      rd_chk(ADDR_STATUS, 32'h62, "rc slower");
      wait_done();
      rd_chk(ADDR_RESULT, 32'haa, "rc code");
      $display("rc clock test done");
   endtask

   task automatic t_stop;
      axw(ADDR_STATUS, 8'h64);
      stop_mode <= 1'b1;
      ticks(300);
      chk({31'h0, afe.conv_en | afe.rc_osc_on}, 32'h0,
          "stop");
      rd_chk(ADDR_STATUS, 32'h64, "no done");
      stop_mode <= 1'b0;
      wait_done();
      rd_chk(ADDR_RESULT, 32'hff, "over range");
      $display("stop test done");
   endtask

   task automatic t_off;
      axw(ADDR_STATUS, 8'h07);
      ticks(100);
      chk({31'h0, afe.conv_en}, 32'h0, "powered off");
      rd_chk(ADDR_STATUS, 32'h07, "no conversion");
      $display("power off test done");
   endtask

   // Hang guard; a full run needs well under a tenth of this
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 50000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // Second reset lands with the converter running
   initial begin
      t_reset();
      t_port();
      t_conv();
      t_abort();
      t_rc();
      t_stop();
      t_reset();
      t_off();
      report_and_stop();
   end
endmodule
`default_nettype wire
